/* include/supervisor_pkg.sv */
// Constants and carrier types for the triple-supply reset supervisor.
// Assumes a 50 MHz reference clock; no other file is needed.
package supervisor_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_HZ = 50_000_000;
   // Reset timeout scale in nanoseconds per picofarad (3.30 us/pF).
   localparam int unsigned RESET_NS_PER_PF = 3300;
   // Watchdog timeout scale in nanoseconds per picofarad (21.8 us/pF).
   localparam int unsigned WDOG_NS_PER_PF = 21800;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int unsigned RESET_CAP_PF = 1500;
   localparam int unsigned WDOG_CAP_PF = 1500;
   localparam longint unsigned RESET_TIMEOUT_NS = longint'(RESET_NS_PER_PF) * RESET_CAP_PF;
   localparam longint unsigned WDOG_TIMEOUT_NS = longint'(WDOG_NS_PER_PF) * WDOG_CAP_PF;
   localparam int unsigned RESET_CYCLES = int'(RESET_TIMEOUT_NS / CLK_PERIOD_NS);
   localparam int unsigned WDOG_CYCLES = int'(WDOG_TIMEOUT_NS / CLK_PERIOD_NS);
   localparam int unsigned CNT_W = 32;
   localparam logic [1:0] SYNC_RESET = 2'h0;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic sense_3v3;
      logic sense_5v;
      logic sense_adjustable;
      logic override_match;
      logic above_4v15;
   } supply_in_t;

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_TIMING,
      ST_RUN
   } sup_state_t;

endpackage : supervisor_pkg

/* hdl/triple_supply_reset_watchdog.sv */
// Triple-supply reset supervisor with a watchdog timer.
// Assumes asynchronous supply comparator and kick inputs, synchronised here.
//
// Behaviour
// R1 - Reset is held low while any of the three supply-valid inputs is false; on the 5V variant override_match drops sense_5v or sense_3v3.
// R2 - Once all supplies are valid the reset timer runs and reset releases after its full period.
// R3 - A supply going invalid drives reset low at once and abandons any timing in progress.
// R4 - The watchdog counter is cleared and stopped whenever reset is asserted.
// R5 - The watchdog starts when the reset timer expires and reset is released.
// R6 - Any edge on the kick input restarts the watchdog from zero and reset stays released.
// R7 - A watchdog expiry asserts reset and starts the reset timer, then the watchdog runs again.
// R8 - The processor must toggle the kick input at least once per watchdog period.
// R9 - The reset timeout is a parameter scaled at 3.30 us per pF of timing capacitance.
// R10 - The watchdog timeout is an independent parameter scaled at 21.8 us per pF.
// R11 - With kick and period inputs both low the watchdog never resets the system.
// R12 - On the 5V variant a matched 5V input below 4.15V is ignored so only 3.3V is checked.
// R13 - Matched inputs above 4.15V re-enable the 5V check and ignore the 3.3V check.
// R14 - Reset is active low and open drain, only ever driven low.
// R15 - Supply and override indications are synchronised and timeouts are clock counters.
`timescale 1ns/1ps
`default_nettype none
module triple_supply_reset_watchdog #(
   parameter int unsigned RESET_CYCLES = supervisor_pkg::RESET_CYCLES,
   parameter int unsigned WDOG_CYCLES = supervisor_pkg::WDOG_CYCLES,
   parameter bit FIVE_VOLT_VARIANT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire supervisor_pkg::supply_in_t supply_in,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_period_cap,
   output logic reset_out_n_o,
   output logic reset_out_n_oe,
   output logic reset_active
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   localparam int SYNC_W = 7;
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] synced;

   assign raw_in = {supply_in, watchdog_kick_in, watchdog_period_cap};

   for (genvar b = 0; b < SYNC_W; b++) begin : g_sync
      logic stage1_q;
      logic stage1_d;
      logic stage2_q;
      logic stage2_d;

      always_comb begin
         stage1_d = raw_in[b]; // [R15]
         stage2_d = stage1_q; // [R15]
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            stage1_q <= supervisor_pkg::SYNC_RESET[0];
            stage2_q <= supervisor_pkg::SYNC_RESET[1];
         end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
         end
      end

      assign synced[b] = stage2_q;
   end

   supervisor_pkg::supply_in_t sup_s;
   logic kick_s;
   logic period_en_s;
   assign sup_s = supervisor_pkg::supply_in_t'(synced[SYNC_W-1:2]);
   assign kick_s = synced[1];
   assign period_en_s = synced[0];

   // ****************************************************************
   // Kick edge detector
   // ****************************************************************
   logic kick_prev_q;
   logic kick_prev_d;
   logic kick_edge;

   always_comb begin
      kick_prev_d = kick_s;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         kick_prev_q <= 1'b0;
      end else begin
         kick_prev_q <= kick_prev_d;
      end
   end

   assign kick_edge = kick_s ^ kick_prev_q; // [R6]

   // ****************************************************************
   // Supply qualification
   // ****************************************************************
   logic ok_5v;
   logic ok_3v3;
   logic all_ok;

   always_comb begin
      ok_5v = sup_s.sense_5v;
      ok_3v3 = sup_s.sense_3v3;
      if (FIVE_VOLT_VARIANT && sup_s.override_match) begin
         if (!sup_s.above_4v15) begin
            ok_5v = 1'b1; // [R12]
         end else begin
            ok_3v3 = 1'b1; // [R13]
         end
      end
      all_ok = ok_5v && ok_3v3 && sup_s.sense_adjustable; // [R1]
   end

   // ****************************************************************
   // Reset and watchdog sequencer
   // ****************************************************************
   supervisor_pkg::sup_state_t state_q;
   supervisor_pkg::sup_state_t state_d;
   logic rst_low_q;
   logic rst_low_d;
   logic wdog_en;
   logic reset_done;
   logic wdog_done;
   logic [supervisor_pkg::CNT_W-1:0] rtim_q;
   logic [supervisor_pkg::CNT_W-1:0] wdog_q;

   assign wdog_en = kick_s || period_en_s; // [R11]
   assign reset_done = (rtim_q >= RESET_CYCLES - 1); // [R9]
   assign wdog_done = wdog_en && !kick_edge && (wdog_q >= WDOG_CYCLES - 1); // [R10]

   always_comb begin
      state_d = state_q;
      rst_low_d = 1'b1;
      if (!all_ok) begin
         state_d = supervisor_pkg::ST_HOLD; // [R3]
      end else begin
         unique case (state_q)
            supervisor_pkg::ST_HOLD: begin
               state_d = supervisor_pkg::ST_TIMING; // [R2]
            end
            supervisor_pkg::ST_TIMING: begin
               if (reset_done) begin
                  state_d = supervisor_pkg::ST_RUN; // [R5]
                  rst_low_d = 1'b0;
               end
            end
            supervisor_pkg::ST_RUN: begin
               rst_low_d = 1'b0;
               if (wdog_done) begin
                  state_d = supervisor_pkg::ST_TIMING; // [R7]
                  rst_low_d = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= supervisor_pkg::ST_HOLD;
         rst_low_q <= 1'b1;
      end else begin
         state_q <= state_d;
         rst_low_q <= rst_low_d;
      end
   end

   // ****************************************************************
   // Reset timer
   // ****************************************************************
   logic [supervisor_pkg::CNT_W-1:0] rtim_d;

   always_comb begin
      rtim_d = '0;
      if (all_ok && (state_q == supervisor_pkg::ST_TIMING) && !reset_done) begin
         rtim_d = rtim_q + 1'b1; // [R2]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rtim_q <= '0;
      end else begin
         rtim_q <= rtim_d;
      end
   end

   // ****************************************************************
   // Watchdog timer
   // ****************************************************************
   logic [supervisor_pkg::CNT_W-1:0] wdog_d;

   always_comb begin
      wdog_d = '0; // [R4]
      if (all_ok && (state_q == supervisor_pkg::ST_RUN) && wdog_en && !kick_edge && !wdog_done) begin
         wdog_d = wdog_q + 1'b1; // [R6]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdog_q <= '0;
      end else begin
         wdog_q <= wdog_d;
      end
   end

   // ****************************************************************
   // Open-drain reset output
   // ****************************************************************
   logic pin_data_q;
   logic pin_data_d;

   assign pin_data_d = 1'b0; // [R14]

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_data_q <= 1'b0;
      end else begin
         pin_data_q <= pin_data_d;
      end
   end

   assign reset_out_n_o = pin_data_q; // [R14]
   assign reset_out_n_oe = rst_low_q; // [R14]
   assign reset_active = rst_low_q; // [R1]

endmodule : triple_supply_reset_watchdog
`default_nettype wire

/* tb/supervisor_checker.sv */
// Port checker for the reset supervisor.
// Assumes it is bound to the design top.
`timescale 1ns/1ps
`default_nettype none
module supervisor_checker #(parameter int unsigned RESET_CYCLES = 20,
   parameter int unsigned WDOG_CYCLES = 50) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire supervisor_pkg::supply_in_t supply_in,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_period_cap,
   input wire logic reset_out_n_o,
   input wire logic reset_out_n_oe,
   input wire logic reset_active
);
   // ****
   // Assertions.
   // ****
   int q_q, ok_q;
   logic k_q;
   wire logic dis = !watchdog_kick_in && !watchdog_period_cap;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {q_q, ok_q, k_q} <= '0;
      end else begin
         q_q <= (reset_out_n_oe || dis || k_q != watchdog_kick_in) ? 0 : q_q + 1;
         ok_q <= (&supply_in[4:2] && !supply_in.override_match) ? ok_q + 1 : 0;
         k_q <= watchdog_kick_in;
      end
   end
   sequence s_up; ##3 reset_out_n_oe; endsequence
   property p_adj; !supply_in.sense_adjustable |-> s_up; endproperty
   a_adj: assert property (p_adj) else $error("adj");
   property p_3v3; !supply_in.sense_3v3 && !supply_in.override_match |-> s_up; endproperty
   a_3v3: assert property (p_3v3) else $error("3v3");
   property p_pin; reset_out_n_o == 1'b0; endproperty
   a_pin: assert property (p_pin) else $error("pin");
   property p_act; reset_active == reset_out_n_oe; endproperty
   a_act: assert property (p_act) else $error("act");
   property p_rel; $fell(reset_out_n_oe) |-> $past(reset_out_n_oe, RESET_CYCLES); endproperty
   a_rel: assert property (p_rel) else $error("rel");
   property p_max; q_q <= WDOG_CYCLES + 4; endproperty
   a_max: assert property (p_max) else $error("max");
   property p_min; $rose(reset_out_n_oe) && ok_q > 4 |-> !$past(reset_out_n_oe, WDOG_CYCLES - 1); endproperty
   a_min: assert property (p_min) else $error("min");
   property p_off; dis && $past(dis, 5) && ok_q > 4 |-> !$rose(reset_out_n_oe); endproperty
   a_off: assert property (p_off) else $error("off");
endmodule : supervisor_checker
bind triple_supply_reset_watchdog supervisor_checker #(.RESET_CYCLES(RESET_CYCLES),
   .WDOG_CYCLES(WDOG_CYCLES)) supervisor_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
   .supply_in(supply_in), .watchdog_kick_in(watchdog_kick_in),
   .watchdog_period_cap(watchdog_period_cap), .reset_out_n_o(reset_out_n_o),
   .reset_out_n_oe(reset_out_n_oe), .reset_active(reset_active));
`default_nettype wire

/* tb/uproc_model.sv */
// Processor model that toggles the kick input.
// Assumes the bench resolves the reset line.
`timescale 1ns/1ps
`default_nettype none
module uproc_model (
   input wire logic ref_clk,
   input wire logic reset_line,
   input wire logic [7:0] gap,
   output logic kick
);
   // ****
   // Kick generator.
   // ****
   int cnt = 0;
   initial kick = 1'b0;
   always @(negedge ref_clk) begin
      cnt = (reset_line && cnt < gap) ? cnt + 1 : 0;
      if (gap == 8'h00) kick = 1'b0;
      else if (cnt == gap) kick = ~kick;
   end
endmodule : uproc_model
`default_nettype wire

/* tb/triple_supply_reset_watchdog_bench.sv */
// Bench with a cycle model of the reset pin.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
module triple_supply_reset_watchdog_bench;
   // ****
   // Stimulus, model and comparison.
   // ****
   localparam int RC = 20;
   localparam int WC = 50;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cap = 1'b1;
   logic kick, o, oe, act, k3;
   supervisor_pkg::supply_in_t sup = 5'h1C;
   logic [7:0] gap = 8'h0A;
   logic [6:0] p1, p2;
   logic h;
   int num_errors = 0, checked = 0, cyc = 0, ms, mc, mw;
   int unsigned rng = 38;
   triple_supply_reset_watchdog #(.RESET_CYCLES(RC), .WDOG_CYCLES(WC))
      triple_supply_reset_watchdog_i (.ref_clk(ref_clk), .rst_n(rst_n), .supply_in(sup),
      .watchdog_kick_in(kick), .watchdog_period_cap(cap), .reset_out_n_o(o),
      .reset_out_n_oe(oe), .reset_active(act));
   uproc_model uproc_model_i (.ref_clk(ref_clk), .reset_line(oe ? o : 1'b1), .gap(gap), .kick(kick));
   initial forever #10 ref_clk = ~ref_clk;
   function automatic int unsigned xs(input int unsigned v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction : xs
   task automatic check(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t reset pin", $time);
      end
   endtask : check
   task automatic close_out;
      if (num_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic run(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : run
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {p1, p2, k3, ms} = '0;
         h = 1'b1;
      end else begin
         if (!(p2[4] && (p2[3] ? (p2[2] ? p2[5] : p2[6]) : p2[6] && p2[5]))) ms = 0;
         else if (ms == 0) ms = 1;
         else if (ms == 1 && mc < RC - 1) mc++;
         else if (ms == 1) ms = 2;
         else if (p2[1] != k3 || !(p2[1] | p2[0])) mw = 0;
         else if (mw < WC - 1) mw++;
         else ms = 1;
         if (ms != 2) mw = 0;
         if (ms != 1) mc = 0;
         k3 = p2[1];
         p2 = p1;
         p1 = {sup, kick, cap};
         h = (ms != 2);
      end
   end
   always @(negedge ref_clk) begin
      if (rst_n) begin
         check(oe, h);
         check(act, h);
         check(o, 1'b0);
      end
      if (++cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      run(12);
      rst_n = 1'b1;
      run(300);
      gap = 8'h00;
      run(300);
      gap = 8'h0A;
      repeat (6) begin
         rng = xs(rng);
         sup[2 + rng % 3] = 1'b0;
         run(rng[2:0] + 1);
         sup = 5'h1C;
         run(rng[9:4] + 8);
      end
      gap = 8'h00;
      cap = 1'b0;
      run(300);
      sup = 5'h16;
      run(100);
      sup = 5'h06;
      run(40);
      sup = 5'h0F;
      run(100);
      sup = 5'h07;
      run(60);
      close_out();
   end
endmodule : triple_supply_reset_watchdog_bench
`default_nettype wire
